// file: verilog/sfca_pkg.sv
// Shared constants and types for the serial flash command framing pair.
// Assumes a 25 MHz system clock on both ends and a slow link clock.
package sfca_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_READ4B        = 8'h13;
  localparam logic [7:0] OP_PROGRAM       = 8'h02;
  localparam logic [7:0] OP_PROGRAM4B     = 8'h12;
  localparam logic [7:0] OP_SECT_ERASE    = 8'h20;
  localparam logic [7:0] OP_SECT_ERASE4B  = 8'h21;
  localparam logic [7:0] OP_BLK_ERASE     = 8'hd8;
  localparam logic [7:0] OP_BLK_ERASE4B   = 8'hdc;
  localparam logic [7:0] OP_CHIP_ERASE    = 8'h60;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_ENTER_WIDE    = 8'hb7;
  localparam logic [7:0] OP_EXIT_WIDE     = 8'he9;
  localparam logic [7:0] OP_WRITE_UPPER   = 8'hc5;
  localparam logic [7:0] OP_READ_UPPER    = 8'hc8;

  // ---------------------------------------------------------------
  // Array geometry, reset values, counts
  // ---------------------------------------------------------------
  localparam int         ARRAY_AW      = 26;
  localparam logic [9:0] TOP_BLOCK     = 10'h3ff;
  localparam logic [5:0] ADDR3_LAST    = 6'h17;
  localparam logic [5:0] ADDR4_LAST    = 6'h1f;
  localparam logic [5:0] BYTE_LAST     = 6'h07;
  localparam logic [1:0] UPPER_RESET   = 2'h0;
  localparam logic [6:0] STATUS_RESET  = 7'h00;
  localparam int         HALF_DEFAULT  = 4;

  // ---------------------------------------------------------------
  // Host control registers (byte offsets on the Avalon slave)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_ADDR  = 4'h4;
  localparam logic [3:0] REG_LEN   = 4'h8;
  localparam logic [3:0] REG_STAT  = 4'hc;
  localparam int         CTRL_GO   = 31;

  typedef enum logic [5:0] {
    FS_IDLE = 6'h01, FS_OPC = 6'h02, FS_ADDR = 6'h04,
    FS_DIN  = 6'h08, FS_DOUT = 6'h10, FS_STBY = 6'h20
  } sfca_dev_state_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h1, HS_RUN = 3'h2, HS_GAP = 3'h4
  } sfca_host_state_e;

endpackage

// file: verilog/sfca_if.sv
// Serial link between the flash end and the controller end.
// Assumes the host treats the data-out line as pulled up when released.
`timescale 1ns/1ps
`default_nettype none
interface sfca_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport flash (input cs_n, input sclk, input mosi, output miso, output miso_oe);
  modport host  (output cs_n, output sclk, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

// file: verilog/sfca_flash.sv
// Flash end: command framing, address width selection, upper segment.
// Assumes link pins arrive asynchronously; user side is on CLK_SYS.
// Overview of operation
// - Sectors are 4K, numbered up from zero
// - End blocks lock per 4K sector
// - Other blocks lock as whole 64K
// - Host polls status before each command
// - Invalid command: standby, output off till deselect
// - Valid command stays active until deselect
// - Sample on clock rise, launch on fall
// - Clock modes 0 and 3 both work
// - Reads may end after any bit
// - Write commands need whole bytes or rejected
// - Array access ignored while busy
// - Enter wide sets flag, 32-bit addresses
// - Exit wide returns to 3-byte addresses
// - Four-byte variants always take 32 bits
// - Wide mode ignores upper segment register
// - Eight-bit upper register supplies top bits
// - Upper bits 7..2 read zero, reset zero
// - Two low bits pick one of four segments
// - Continuous read runs into next segment
// - Random read starts in selected segment
// - Chip erase ignores selected segment
// - Erase and program stay in segment
`timescale 1ns/1ps
`default_nettype none
module sfca_flash (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESET_N,
  sfca_if.flash                            LINK,
  input  wire logic                        BUSY,
  input  wire logic [7:0]                  RD_DATA,
  output logic [sfca_pkg::ARRAY_AW-1:0]    RD_ADDR,
  output logic                             EXEC,
  output logic [7:0]                       EXEC_OP,
  output logic [sfca_pkg::ARRAY_AW-1:0]    EXEC_ADDR,
  output logic [7:0]                       EXEC_DATA,
  output logic [13:0]                      EXEC_LOCK_UNIT,
  output logic                             EXEC_LOCK_FINE,
  output logic                             WIDE_MODE,
  output logic [1:0]                       UPPER_SEG,
  output logic                             ACTIVE
);

  typedef struct packed {
    logic valid;
    logic addr;
    logic four;
    logic rd;
    logic out;
    logic data;
    logic arr;
  } sfca_dec_s;

  typedef struct packed {
    sfca_pkg::sfca_dev_state_e   st;
    logic [1:0]                  cs_sy;
    logic [1:0]                  sck_sy;
    logic [1:0]                  mosi_sy;
    logic                        cs_d;
    logic                        sck_d;
    logic [7:0]                  opc;
    sfca_dec_s                   dec;
    logic [31:0]                 sh;
    logic [5:0]                  cnt;
    logic                        got;
    logic [7:0]                  dbyte;
    logic                        wide;
    logic [1:0]                  upper;
    logic [6:0]                  stat;
    logic                        miso;
    logic                        miso_oe;
    logic [7:0]                  osh;
    logic [2:0]                  ocnt;
    logic [sfca_pkg::ARRAY_AW-1:0] rd_addr;
    logic [sfca_pkg::ARRAY_AW-1:0] xaddr;
    logic                        exec;
    logic [7:0]                  xop;
    logic [7:0]                  xdata;
    logic [13:0]                 xunit;
    logic                        xfine;
    logic                        active;
  } sfca_flash_s;

  sfca_flash_s s_reg;
  sfca_flash_s s_next;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // Busy only matters for array commands; status reads always pass
  function automatic sfca_dec_s decode(input logic [7:0] op, input logic busy);
    sfca_dec_s d;
    d = '0;
    d.valid = 1'b1;
    case (op)
      sfca_pkg::OP_READ:         begin d.addr = 1'b1; d.rd = 1'b1; d.out = 1'b1; d.arr = 1'b1; end
      sfca_pkg::OP_READ4B:       begin d.addr = 1'b1; d.four = 1'b1; d.rd = 1'b1; d.out = 1'b1;
                                       d.arr = 1'b1; end
      sfca_pkg::OP_PROGRAM,
      sfca_pkg::OP_SECT_ERASE,
      sfca_pkg::OP_BLK_ERASE:    begin d.addr = 1'b1; d.arr = 1'b1; d.data = (op == sfca_pkg::OP_PROGRAM); end
      sfca_pkg::OP_PROGRAM4B,
      sfca_pkg::OP_SECT_ERASE4B,
      sfca_pkg::OP_BLK_ERASE4B:  begin d.addr = 1'b1; d.four = 1'b1; d.arr = 1'b1;
                                       d.data = (op == sfca_pkg::OP_PROGRAM4B); end
      sfca_pkg::OP_CHIP_ERASE:   d.arr = 1'b1;
      sfca_pkg::OP_WRITE_STATUS,
      sfca_pkg::OP_WRITE_UPPER:  d.data = 1'b1;
      sfca_pkg::OP_READ_STATUS,
      sfca_pkg::OP_READ_UPPER:   d.out = 1'b1;
      sfca_pkg::OP_ENTER_WIDE,
      sfca_pkg::OP_EXIT_WIDE:    d.valid = 1'b1;
      default:                   d.valid = 1'b0;
    endcase
    if (busy && d.arr) begin
      d.valid = 1'b0;
    end
    return d;
  endfunction

  // Synchronised link levels and their edges
  logic       cs;
  logic       sck;
  logic       mosi;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic [7:0] op_in;
  logic [31:0] sh_in;
  sfca_dec_s  dec_in;

  assign cs       = s_reg.cs_sy[1];
  assign sck      = s_reg.sck_sy[1];
  assign mosi     = s_reg.mosi_sy[1];
  assign sck_rise = sck & ~s_reg.sck_d;
  assign sck_fall = ~sck & s_reg.sck_d;
  assign cs_rise  = cs & ~s_reg.cs_d;
  assign cs_fall  = ~cs & s_reg.cs_d;
  assign sh_in    = {s_reg.sh[30:0], mosi};
  assign op_in    = sh_in[7:0];
  assign dec_in   = decode(op_in, BUSY);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Edges only count while selected, so the idle level of the clock
  // (low or high) never matters and the first stray fall is harmless
  always_comb begin
    s_next         = s_reg;
    s_next.exec    = 1'b0;
    s_next.cs_sy   = {s_reg.cs_sy[0], LINK.cs_n};
    s_next.sck_sy  = {s_reg.sck_sy[0], LINK.sclk};
    s_next.mosi_sy = {s_reg.mosi_sy[0], LINK.mosi};
    s_next.cs_d    = cs;
    s_next.sck_d   = sck;
    if (cs_rise) begin
      // Only complete write-type frames that end on a byte run
      if (s_reg.st == sfca_pkg::FS_DIN && s_reg.cnt[2:0] == 3'h0 &&
          (!s_reg.dec.data || s_reg.got)) begin
        s_next.exec  = 1'b1;
        s_next.xop   = s_reg.opc;
        s_next.xdata = s_reg.dbyte;
        s_next.xfine = (s_reg.xaddr[25:16] == 10'h000) ||
                       (s_reg.xaddr[25:16] == sfca_pkg::TOP_BLOCK);
        // Fine units are sectors, coarse ones name the first sector
        s_next.xunit = s_next.xfine ? s_reg.xaddr[25:12]
                                    : {s_reg.xaddr[25:16], 4'h0};
        case (s_reg.opc)
          sfca_pkg::OP_ENTER_WIDE:   s_next.wide  = 1'b1;
          sfca_pkg::OP_EXIT_WIDE:    s_next.wide  = 1'b0;
          sfca_pkg::OP_WRITE_UPPER:  s_next.upper = s_reg.dbyte[1:0];
          sfca_pkg::OP_WRITE_STATUS: s_next.stat  = s_reg.dbyte[7:1];
          default:                   s_next.stat  = s_reg.stat;
        endcase
      end
      s_next.st      = sfca_pkg::FS_IDLE;
      s_next.miso_oe = 1'b0;
      s_next.active  = 1'b0;
    end else if (cs_fall) begin
      s_next.st      = sfca_pkg::FS_OPC;
      s_next.cnt     = 6'h00;
      s_next.ocnt    = 3'h0;                              // Cut frames leave no bit offset
      s_next.got     = 1'b0;
      s_next.miso_oe = 1'b0;
    end else if (!cs) begin
      case (s_reg.st)
        sfca_pkg::FS_OPC: begin
          if (sck_rise) begin
            s_next.sh  = sh_in;
            s_next.cnt = s_reg.cnt + 6'h01;
            if (s_reg.cnt == sfca_pkg::BYTE_LAST) begin
              s_next.opc   = op_in;
              s_next.dec   = dec_in;
              s_next.cnt   = 6'h00;
              s_next.xaddr = '0;
              if (!dec_in.valid) begin
                s_next.st = sfca_pkg::FS_STBY;
              end else begin
                s_next.active = 1'b1;
                if (dec_in.addr) begin
                  s_next.st = sfca_pkg::FS_ADDR;
                end else if (dec_in.out) begin
                  s_next.st = sfca_pkg::FS_DOUT;
                end else begin
                  s_next.st = sfca_pkg::FS_DIN;
                end
              end
            end
          end
        end
        sfca_pkg::FS_ADDR: begin
          if (sck_rise) begin
            s_next.sh  = sh_in;
            s_next.cnt = s_reg.cnt + 6'h01;
            // Four-byte variants or wide mode: 32 bits, segment ignored
            if ((s_reg.dec.four || s_reg.wide) ? (s_reg.cnt == sfca_pkg::ADDR4_LAST)
                                               : (s_reg.cnt == sfca_pkg::ADDR3_LAST)) begin
              if (s_reg.dec.four || s_reg.wide) begin
                s_next.xaddr = sh_in[25:0];
              end else begin
                s_next.xaddr = {s_reg.upper, sh_in[23:0]};
              end
              s_next.rd_addr = s_next.xaddr;
              s_next.cnt     = 6'h00;
              s_next.st      = s_reg.dec.out ? sfca_pkg::FS_DOUT : sfca_pkg::FS_DIN;
            end
          end
        end
        sfca_pkg::FS_DIN: begin
          if (sck_rise) begin
            s_next.sh  = sh_in;
            s_next.cnt = s_reg.cnt + 6'h01;
            if (s_reg.cnt == sfca_pkg::BYTE_LAST) begin
              s_next.got   = 1'b1;
              s_next.dbyte = op_in;
            end
          end
        end
        sfca_pkg::FS_DOUT: begin
          if (sck_fall) begin
            s_next.miso_oe = 1'b1;
            s_next.ocnt    = s_reg.ocnt + 3'h1;
            if (s_reg.ocnt == 3'h0) begin
              // Array reads step through the whole array, carrying into the next segment
              if (s_reg.dec.rd) begin
                s_next.osh     = RD_DATA;
                s_next.rd_addr = s_reg.rd_addr + 26'h0000001;
              end else if (s_reg.opc == sfca_pkg::OP_READ_STATUS) begin
                s_next.osh = {s_reg.stat, BUSY};
              end else begin
                s_next.osh = {6'h00, s_reg.upper};
              end
              s_next.miso = s_next.osh[7];
              s_next.osh  = {s_next.osh[6:0], 1'b0};
            end else begin
              s_next.miso = s_reg.osh[7];
              s_next.osh  = {s_reg.osh[6:0], 1'b0};
            end
          end
        end
        default: s_next.st = s_reg.st;                    // Idle and standby wait
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      s_reg         <= '0;
      s_reg.st      <= sfca_pkg::FS_IDLE;
      s_reg.cs_sy   <= 2'h3;
      s_reg.cs_d    <= 1'b1;
      s_reg.upper   <= sfca_pkg::UPPER_RESET;
      s_reg.stat    <= sfca_pkg::STATUS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign LINK.miso      = s_reg.miso;
  assign LINK.miso_oe   = s_reg.miso_oe;
  assign RD_ADDR        = s_reg.rd_addr;
  assign EXEC           = s_reg.exec;
  assign EXEC_OP        = s_reg.xop;
  assign EXEC_ADDR      = s_reg.xaddr;
  assign EXEC_DATA      = s_reg.xdata;
  assign EXEC_LOCK_UNIT = s_reg.xunit;
  assign EXEC_LOCK_FINE = s_reg.xfine;
  assign WIDE_MODE      = s_reg.wide;
  assign UPPER_SEG      = s_reg.upper;
  assign ACTIVE         = s_reg.active;

endmodule
`default_nettype wire

// file: verilog/sfca_host.sv
// Controller end: runs one framed command per software order.
// Assumes an Avalon-MM master on CLK_SYS and the flash end on the link.
`timescale 1ns/1ps
`default_nettype none
module sfca_host #(
  parameter int HALF_CYCLES = sfca_pkg::HALF_DEFAULT
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  sfca_if.host             LINK,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST
);

  typedef struct packed {
    sfca_pkg::sfca_host_state_e st;
    logic [1:0]  miso_sy;
    logic [7:0]  div;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        primed;
    logic [39:0] sh;
    logic [15:0] bits;
    logic [15:0] hdr;
    logic [15:0] txend;
    logic [15:0] total;
    logic [7:0]  rsh;
    logic [2:0]  rcnt;
    logic [7:0]  rx_byte;
    logic        rx_valid;
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [31:0] len;
    logic        wait_r;
    logic [31:0] rdata;
  } sfca_host_s;

  sfca_host_s s_reg;
  sfca_host_s s_next;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  // Byte-lane merge for partial Avalon writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic        tick;
  logic        req;
  logic        stat_rd;
  logic [15:0] nb;
  logic [2:0]  ab;

  assign tick    = (s_reg.div == 8'h00);
  assign req     = AVS_READ | AVS_WRITE;
  assign stat_rd = AVS_READ & ~s_reg.wait_r & (AVS_ADDRESS == sfca_pkg::REG_STAT);
  assign nb      = s_reg.bits + 16'h0001;
  assign ab      = s_reg.ctrl[10:8];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_next         = s_reg;
    // A released data line reads as its pull-up level, not the last bit
    s_next.miso_sy = {s_reg.miso_sy[0], LINK.miso_oe ? LINK.miso : 1'b1};
    s_next.div     = tick ? HALF_LAST : s_reg.div - 8'h01;
    // Bus slave: data prepared with waitrequest high, acted on when low
    s_next.wait_r  = ~(req & s_reg.wait_r);
    if (req && s_reg.wait_r) begin
      case (AVS_ADDRESS)
        sfca_pkg::REG_CTRL: s_next.rdata = s_reg.ctrl;
        sfca_pkg::REG_ADDR: s_next.rdata = s_reg.addr;
        sfca_pkg::REG_LEN:  s_next.rdata = s_reg.len;
        sfca_pkg::REG_STAT: s_next.rdata = {16'h0000, s_reg.rx_byte, 6'h00,
                                            s_reg.rx_valid, s_reg.st != sfca_pkg::HS_IDLE};
        default:            s_next.rdata = 32'h00000000;
      endcase
    end
    if (stat_rd) begin
      s_next.rx_valid = 1'b0;
    end
    // Self-clear first, so a write that sets GO wins for one cycle
    s_next.ctrl[sfca_pkg::CTRL_GO] = 1'b0;
    if (AVS_WRITE && !s_reg.wait_r) begin
      case (AVS_ADDRESS)
        sfca_pkg::REG_CTRL: s_next.ctrl = merge(s_reg.ctrl, AVS_WRITEDATA, AVS_BYTEENABLE);
        sfca_pkg::REG_ADDR: s_next.addr = merge(s_reg.addr, AVS_WRITEDATA, AVS_BYTEENABLE);
        sfca_pkg::REG_LEN:  s_next.len  = merge(s_reg.len, AVS_WRITEDATA, AVS_BYTEENABLE);
        default:            s_next.len  = s_reg.len;
      endcase
    end
    case (s_reg.st)
      sfca_pkg::HS_IDLE: begin
        // Software polls status before ordering the next command
        if (s_reg.ctrl[sfca_pkg::CTRL_GO]) begin
          s_next.st     = sfca_pkg::HS_RUN;
          s_next.sh     = (ab == 3'h4) ? {s_reg.ctrl[7:0], s_reg.addr}
                                       : {s_reg.ctrl[7:0], s_reg.addr[23:0], 8'h00};
          s_next.hdr    = {10'h000, ab, 3'h0} + 16'h0008;
          s_next.txend  = s_next.hdr + {5'h00, s_reg.len[7:0], 3'h0};
          s_next.total  = s_next.txend + {4'h0, s_reg.len[27:16]};
          s_next.bits   = 16'h0000;
          s_next.rcnt   = 3'h0;
          s_next.cs_n   = 1'b0;
          s_next.sclk   = s_reg.ctrl[11];
          s_next.primed = ~s_reg.ctrl[11];
          s_next.mosi   = s_reg.ctrl[7];
          s_next.div    = HALF_LAST;
        end
      end
      sfca_pkg::HS_RUN: begin
        if (tick) begin
          if (!s_reg.sclk) begin
            s_next.sclk = 1'b1;
          end else if (!s_reg.primed) begin
            s_next.sclk   = 1'b0;
            s_next.primed = 1'b1;
          end else begin
            // Post-rise: take the bit launched on the last fall
            s_next.bits = nb;
            if (s_reg.bits >= s_reg.txend) begin
              s_next.rsh  = {s_reg.rsh[6:0], s_reg.miso_sy[1]};
              s_next.rcnt = s_reg.rcnt + 3'h1;
              if (s_reg.rcnt == 3'h7) begin
                s_next.rx_byte  = s_next.rsh;
                s_next.rx_valid = 1'b1;                   // Set wins over clear
              end
            end
            if (nb == s_reg.total) begin
              s_next.st   = sfca_pkg::HS_GAP;
              s_next.sclk = s_reg.ctrl[11];
            end else begin
              s_next.sclk = 1'b0;
              s_next.sh   = {s_reg.sh[38:0], 1'b0};
              s_next.mosi = (nb < s_reg.hdr) ? s_reg.sh[38] :
                            (nb < s_reg.txend) ? s_reg.ctrl[5'd23 - {2'h0, nb[2:0]}] : 1'b0;
            end
          end
        end
      end
      sfca_pkg::HS_GAP: begin
        // One half period low after the last edge, one high before idle
        if (tick) begin
          if (!s_reg.cs_n) begin
            s_next.cs_n = 1'b1;
          end else begin
            s_next.st = sfca_pkg::HS_IDLE;
          end
        end
      end
      default: s_next.st = sfca_pkg::HS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      s_reg        <= '0;
      s_reg.st     <= sfca_pkg::HS_IDLE;
      s_reg.cs_n   <= 1'b1;
      s_reg.wait_r <= 1'b1;
      s_reg.div    <= HALF_LAST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign LINK.cs_n       = s_reg.cs_n;
  assign LINK.sclk       = s_reg.sclk;
  assign LINK.mosi       = s_reg.mosi;
  assign AVS_READDATA    = s_reg.rdata;
  assign AVS_WAITREQUEST = s_reg.wait_r;

endmodule
`default_nettype wire

// file: testbench/sfca_checker.sv
// Link checker between the flash end and the controller end.
// Assumes the link signals as plain inputs on CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
module sfca_checker (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ----
  // Link timing
  // ----
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  chk_oe_after_deselect: assert property ($rose(cs_n) |-> ##6 !miso_oe)
    else $error("data out driven after deselect");
  chk_oe_idle_off: assert property (cs_n [*6] |-> !miso_oe)
    else $error("data out driven while idle");
  chk_oe_rise_framed: assert property ($rose(miso_oe) |-> !cs_n && !sclk)
    else $error("data out enabled outside frame");
  chk_oe_held_frame: assert property ($fell(miso_oe) |-> cs_n || $past(cs_n, 4))
    else $error("data out dropped inside frame");
  chk_miso_on_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk)
    else $error("data out changed while clock high");
  chk_mosi_on_low: assert property (!cs_n && $past(!cs_n) && $changed(mosi) |-> !sclk)
    else $error("data in changed while clock high");
  chk_sclk_half_hold: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("link clock half too short");
  chk_sclk_quiet_open: assert property ($fell(cs_n) |=> $stable(sclk) [*3])
    else $error("link clock moved at frame open");
endmodule
`default_nettype wire

// file: testbench/sfca_tb.sv
// Bench joining both ends over the link, driven through the Avalon slave.
// Assumes HALF_CYCLES at its default and a 25 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module sfca_tb;
  logic        clk = 1'b0, rst_n = 1'b0, busy = 1'b0, rd = 1'b0, wr = 1'b0, oe_seen;
  logic        mode3, exec, ex_f, wide, wt, act, act_seen;
  logic [3:0]  ad = 4'h0;
  logic [31:0] wd = 32'h0, q, rq, a = 32'h0;
  logic [25:0] rd_a, ex_a, got_a;
  logic [13:0] ex_u;
  logic [14:0] got_u;
  logic [7:0]  rx, seg, ex_op, got_op, ex_d, got_d;
  logic [1:0]  useg;
  int          n_errors = 0, comparisons = 0, cyc = 0;
  sfca_if link ();
  sfca_flash sfca_flash_i (.CLK_SYS(clk), .RESET_N(rst_n), .LINK(link), .BUSY(busy),
    .RD_DATA({rd_a[25:24], rd_a[5:0]}), .RD_ADDR(rd_a), .EXEC(exec), .EXEC_OP(ex_op),
    .EXEC_ADDR(ex_a), .EXEC_DATA(ex_d), .EXEC_LOCK_UNIT(ex_u), .EXEC_LOCK_FINE(ex_f),
    .WIDE_MODE(wide), .UPPER_SEG(useg), .ACTIVE(act));
  sfca_host sfca_host_i (.CLK_SYS(clk), .RESET_N(rst_n), .LINK(link), .AVS_ADDRESS(ad),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(q), .AVS_WAITREQUEST(wt));
  sfca_checker sfca_checker_i (.CLK_SYS(clk), .RESET_N(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
  // ----
  // Clock, monitor and timeout
  // ----
  initial forever #20 clk = ~clk;
  // Latch each accepted command, since the pulse lasts one cycle only
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (link.miso_oe === 1'b1) oe_seen <= 1'b1;
    if (act === 1'b1) act_seen <= 1'b1;
    if (exec === 1'b1) begin
      got_a <= ex_a;
      got_u <= {ex_f, ex_u};
      got_op <= ex_op;
      got_d <= ex_d;
    end
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [3:0] adr, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    ad <= adr;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    rq = q;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // One framed command in a random clock mode, then polls until done
  task automatic cmd(input logic [7:0] op, input logic [2:0] nb, input logic [7:0] tx,
                     input logic [7:0] ntx, input logic [11:0] nrx);
    mode3 = 1'($urandom);
    oe_seen = 1'b0;
    act_seen = 1'b0;
    av(1'b1, sfca_pkg::REG_ADDR, a);
    av(1'b1, sfca_pkg::REG_LEN, {4'h0, nrx, 8'h00, ntx});
    av(1'b1, sfca_pkg::REG_CTRL, {8'h80, tx, 4'h0, mode3, nb, op});
    rq = 32'h1;
    while (rq[0] !== 1'b0) av(1'b0, sfca_pkg::REG_STAT, 32'h0);
    rx = rq[15:8];
    repeat (8) @(posedge clk);
  endtask
  // End blocks lock per sector, all others per whole block
  function automatic logic [14:0] unit_exp(input logic [31:0] x);
    if (x[25:16] == 10'h0 || x[25:16] == 10'h3ff) return {1'b1, x[25:12]};
    return {1'b0, x[25:16], 4'h0};
  endfunction
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(9));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    seg = 8'($urandom);
    cmd(sfca_pkg::OP_WRITE_UPPER, 3'h0, seg, 8'h1, 12'h0);
    cmd(sfca_pkg::OP_READ_UPPER, 3'h0, 8'h0, 8'h0, 12'h8);
    chk(rx, {6'h0, seg[1:0]});
    chk(useg, seg[1:0]);
    a = $urandom;
    cmd(sfca_pkg::OP_PROGRAM, 3'h3, 8'h3c, 8'h1, 12'h0);
    chk(got_a, {seg[1:0], a[23:0]});
    chk(got_d, 8'h3c);
    cmd(sfca_pkg::OP_WRITE_UPPER, 3'h0, ~seg, 8'h1, 12'h3);
    chk(useg, seg[1:0]);
    for (int k = 0; k < 3; k++) begin
      a = $urandom;
      a[25:16] = (k == 0) ? 10'h0 : (k == 1) ? sfca_pkg::TOP_BLOCK : 10'(1 + $urandom % 1022);
      cmd(sfca_pkg::OP_SECT_ERASE4B, 3'h4, 8'h0, 8'h0, 12'h0);
      chk(got_u, unit_exp(a));
      chk(got_a, a[25:0]);
    end
    cmd(sfca_pkg::OP_ENTER_WIDE, 3'h0, 8'h0, 8'h0, 12'h0);
    chk(wide, 1'b1);
    a = $urandom;
    cmd(sfca_pkg::OP_PROGRAM, 3'h4, 8'h5a, 8'h1, 12'h0);
    chk(got_a, a[25:0]);
    cmd(sfca_pkg::OP_EXIT_WIDE, 3'h0, 8'h0, 8'h0, 12'h0);
    chk(wide, 1'b0);
    a = 32'hffffff;
    cmd(sfca_pkg::OP_READ, 3'h3, 8'h0, 8'h0, 12'h10);
    chk(rx, {seg[1:0] + 2'h1, 6'h0});
    chk(useg, seg[1:0]);
    chk(act_seen, 1'b1);
    cmd(sfca_pkg::OP_CHIP_ERASE, 3'h0, 8'h0, 8'h0, 12'h0);
    chk(got_a, 26'h0);
    chk(got_op, sfca_pkg::OP_CHIP_ERASE);
    cmd(8'hff, 3'h0, 8'h0, 8'h0, 12'h8);
    chk(oe_seen, 1'b0);
    chk(act_seen, 1'b0);
    busy <= 1'b1;
    cmd(sfca_pkg::OP_READ, 3'h3, 8'h0, 8'h0, 12'h8);
    chk(oe_seen, 1'b0);
    chk(act_seen, 1'b0);
    cmd(sfca_pkg::OP_READ_STATUS, 3'h0, 8'h0, 8'h0, 12'h8);
    chk(rx, 8'h01);
    cmd(sfca_pkg::OP_WRITE_STATUS, 3'h0, 8'ha4, 8'h1, 12'h0);
    cmd(sfca_pkg::OP_READ_STATUS, 3'h0, 8'h0, 8'h0, 12'h8);
    chk(rx, 8'ha5);
    end_sim();
  end
endmodule
`default_nettype wire
